/* pmem_host_pkg.sv */
package pmem_host_pkg;

    localparam int unsigned CLOCK_HZ          = 25_000_000;
    localparam int unsigned CLOCK_PERIOD_NS   = 40;
    // Reset pulse and recovery, in ns
    localparam int unsigned RESET_PULSE_NS    = 200;
    localparam int unsigned RESET_RECOVERY_NS = 200;
    // Read access time and write strobe width, in ns
    localparam int unsigned READ_ACCESS_NS    = 135;
    localparam int unsigned WRITE_PULSE_NS    = 80;
    localparam int unsigned BUS_TURN_NS       = 40;

    localparam int unsigned RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned RESET_RECOVERY_CYC =
        (RESET_RECOVERY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned READ_ACCESS_CYC =
        (READ_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned WRITE_PULSE_CYC =
        (WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned BUS_TURN_CYC =
        (BUS_TURN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    localparam int unsigned COUNT_WIDTH = 8;

    localparam logic [15:0] CMD_READ_ARRAY   = 16'h00ff;
    localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
    localparam logic [7:0]  STATUS_AFTER_RESET = 8'h80;
    localparam logic [7:0]  STATUS_ERROR_MASK  = 8'h3a;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_RESET
    } op_type;

endpackage : pmem_host_pkg

/* pmem_timer_if.sv */
interface pmem_timer_if;
    logic       load;
    logic [7:0] value;
    logic       done;
    modport owner (output load, output value, input done);
    modport timer (input load, input value, output done);
endinterface : pmem_timer_if

/* pmem_host_timer.sv */
module pmem_host_timer (
    input  wire logic   CLOCK,
    input  wire logic   RESET,
    pmem_timer_if.timer tmr
);
    logic [7:0] count_q;
    logic [7:0] count_d;

    always_comb begin
        count_d = count_q;
        if (tmr.load) begin
            count_d = tmr.value;
        end else if (count_q != 8'h00) begin
            count_d = count_q - 8'h01;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            count_q <= 8'h00;
        end else begin
            count_q <= count_d;
        end
    end

    // Done from the count alone, so a load taken on done forms no loop
    assign tmr.done = (count_q == 8'h00);

endmodule : pmem_host_timer

/* pmem_host.sv */
// Summary of operation
// [RULE1] Device shifts serial read data out on falling serial clock, MSB first.
// [RULE2] Interface select low: parallel active, serial output floats.
// [RULE3] Interface select high: serial active, parallel outputs float.
// [RULE4] Unconnected select defaults to parallel; a config cell may disable serial.
// [RULE5] During program supply lockout only reads work; contents stay unchanged.
// [RULE6] Read: reset and write strobe high, chip select and output enable low.
// [RULE7] Output enable high floats data lines and wait output.
// [RULE8] Chip select high puts device in standby with floating outputs.
// [RULE9] Program or erase continues after chip select goes high.
// [RULE10] Write: chip select and strobe low, data latched at first rising edge.
// [RULE11] Output enable with write strobe together is treated as a read.
// [RULE12] Host never asserts output enable and write strobe together.
// [RULE13] Reset low ignores other controls, floats data, aborts, inhibits writes.
// [RULE14] After reset the device is in read array mode, status 0x80.
// [RULE15] Program or erase cut by reset leaves that location invalid.
// [RULE16] Host waits a recovery time after reset before reads or writes.
// [RULE17] Memory reset should follow the processor's system reset.
// [RULE18] Command FFh returns the device to read array mode.
// [RULE19] Status error bits set only by write engine; cleared by reset or 50h.
// [RULE20] Bus decode is level sensitive; reset has priority over all controls.
module pmem_host #(
    parameter int unsigned ADDR_WIDTH = 23,
    parameter int unsigned DATA_WIDTH = 16
) (
    input  wire logic                  CLOCK,
    input  wire logic                  RESET,
    input  wire logic                  REQ_VALID,
    output logic                       REQ_READY,
    input  wire pmem_host_pkg::op_type REQ_OP,
    input  wire logic [ADDR_WIDTH-1:0] REQ_ADDR,
    input  wire logic [DATA_WIDTH-1:0] REQ_WDATA,
    output logic                       RSP_VALID,
    output logic [DATA_WIDTH-1:0]      RSP_RDATA,
    output logic                       ERROR_FLAG,
    output logic [ADDR_WIDTH-1:0]      MEM_ADDR,
    output logic                       MEM_CHIP_SEL_N,
    output logic                       MEM_OUT_EN_N,
    output logic                       MEM_WRITE_N,
    output logic                       MEM_RESET_N,
    output logic                       MEM_PORT_SELECT,
    output logic [DATA_WIDTH-1:0]      MEM_DQ_O,
    output logic                       MEM_DQ_OE,
    input  wire logic [DATA_WIDTH-1:0] MEM_DQ_I
);

    typedef enum logic [2:0] {
        ST_RESET,
        ST_RECOVER,
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_TURN
    } state_type;

    state_type             state_q, state_d;
    logic [ADDR_WIDTH-1:0] addr_q, addr_d;
    logic [DATA_WIDTH-1:0] wdata_q, wdata_d;
    logic [DATA_WIDTH-1:0] rdata_q, rdata_d;
    logic                  rsp_q, rsp_d;
    logic                  err_q, err_d;
    logic                  ce_n_q, ce_n_d;
    logic                  oe_n_q, oe_n_d;
    logic                  we_n_q, we_n_d;
    logic                  rst_n_q, rst_n_d;
    logic                  dq_oe_q, dq_oe_d;

    pmem_timer_if tmr ();

    pmem_host_timer timer_u (
        .CLOCK (CLOCK),
        .RESET (RESET),
        .tmr   (tmr.timer)
    );

    always_comb begin
        state_d   = state_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        rdata_d   = rdata_q;
        rsp_d     = 1'b0;
        err_d     = err_q;
        ce_n_d    = ce_n_q;
        oe_n_d    = oe_n_q;
        we_n_d    = we_n_q;
        rst_n_d   = rst_n_q;
        dq_oe_d   = dq_oe_q;
        tmr.load  = 1'b0;
        tmr.value = 8'h00;
        case (state_q)
            ST_RESET: begin
                // Memory reset held low for the pulse time after OP_RESET, one cycle past system reset [RULE13] [RULE17]
                ce_n_d  = 1'b1;
                oe_n_d  = 1'b1;
                we_n_d  = 1'b1;
                dq_oe_d = 1'b0;
                rst_n_d = 1'b0;
                if (tmr.done) begin
                    rst_n_d   = 1'b1;
                    tmr.load  = 1'b1;
                    tmr.value = 8'(pmem_host_pkg::RESET_RECOVERY_CYC);
                    state_d   = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (tmr.done) begin // [RULE16]
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (REQ_VALID) begin
                    addr_d  = REQ_ADDR;
                    wdata_d = REQ_WDATA;
                    case (REQ_OP)
                        pmem_host_pkg::OP_READ: begin
                            ce_n_d    = 1'b0; // [RULE6]
                            oe_n_d    = 1'b0;
                            we_n_d    = 1'b1;
                            tmr.load  = 1'b1;
                            tmr.value = 8'(pmem_host_pkg::READ_ACCESS_CYC);
                            state_d   = ST_READ;
                        end
                        pmem_host_pkg::OP_WRITE: begin
                            // Command words such as read array use this path [RULE18]
                            ce_n_d    = 1'b0; // [RULE10]
                            oe_n_d    = 1'b1; // [RULE12]
                            we_n_d    = 1'b0;
                            dq_oe_d   = 1'b1;
                            tmr.load  = 1'b1;
                            tmr.value = 8'(pmem_host_pkg::WRITE_PULSE_CYC);
                            state_d   = ST_WRITE;
                        end
                        pmem_host_pkg::OP_RESET: begin
                            rst_n_d   = 1'b0;
                            tmr.load  = 1'b1;
                            tmr.value = 8'(pmem_host_pkg::RESET_PULSE_CYC);
                            state_d   = ST_RESET;
                        end
                        default: begin
                            err_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_READ: begin
                if (tmr.done) begin
                    rdata_d   = MEM_DQ_I;
                    rsp_d     = 1'b1;
                    ce_n_d    = 1'b1; // [RULE8]
                    oe_n_d    = 1'b1; // [RULE7]
                    tmr.load  = 1'b1;
                    tmr.value = 8'(pmem_host_pkg::BUS_TURN_CYC);
                    state_d   = ST_TURN;
                end
            end
            ST_WRITE: begin
                if (tmr.done) begin
                    // Strobes rise together; data held one more cycle [RULE10]
                    we_n_d    = 1'b1;
                    ce_n_d    = 1'b1;
                    rsp_d     = 1'b1;
                    tmr.load  = 1'b1;
                    tmr.value = 8'(pmem_host_pkg::BUS_TURN_CYC);
                    state_d   = ST_TURN;
                end
            end
            ST_TURN: begin
                dq_oe_d = 1'b0;
                if (tmr.done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_q <= ST_RESET;
            addr_q  <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            rsp_q   <= 1'b0;
            err_q   <= 1'b0;
            ce_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            rst_n_q <= 1'b0; // [RULE17]
            dq_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rsp_q   <= rsp_d;
            err_q   <= err_d;
            ce_n_q  <= ce_n_d;
            oe_n_q  <= oe_n_d;
            we_n_q  <= we_n_d;
            rst_n_q <= rst_n_d;
            dq_oe_q <= dq_oe_d;
        end
    end

    assign REQ_READY       = (state_q == ST_IDLE);
    assign RSP_VALID       = rsp_q;
    assign RSP_RDATA       = rdata_q;
    assign ERROR_FLAG      = err_q;
    assign MEM_ADDR        = addr_q;
    assign MEM_CHIP_SEL_N  = ce_n_q;
    assign MEM_OUT_EN_N    = oe_n_q;
    assign MEM_WRITE_N     = we_n_q;
    assign MEM_RESET_N     = rst_n_q;
    assign MEM_PORT_SELECT = 1'b0; // Parallel interface only [RULE2]
    assign MEM_DQ_O        = wdata_q;
    assign MEM_DQ_OE       = dq_oe_q;

    // Recovery count after memory reset release
    logic [7:0] rec_cnt_q;
    logic [7:0] rec_cnt_d;

    always_comb begin
        rec_cnt_d = rec_cnt_q;
        if (!rst_n_q) begin
            rec_cnt_d = 8'h00;
        end else if (rec_cnt_q != 8'hff) begin
            rec_cnt_d = rec_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rec_cnt_q <= 8'h00;
        end else begin
            rec_cnt_q <= rec_cnt_d;
        end
    end

    no_oe_we_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !(!MEM_OUT_EN_N && !MEM_WRITE_N)) // [RULE12]
        else $error("output enable and write strobe both low");
    recovery_wait_a: assert property (@(posedge CLOCK) disable iff (RESET)
        (!MEM_CHIP_SEL_N) |-> (rec_cnt_q >= 8'(pmem_host_pkg::RESET_RECOVERY_CYC))) // [RULE16]
        else $error("access started before reset recovery");
    reset_idle_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !MEM_RESET_N |-> (MEM_CHIP_SEL_N && !MEM_DQ_OE)) // [RULE13]
        else $error("bus active during memory reset");
    read_strobes_a: assert property (@(posedge CLOCK) disable iff (RESET)
        (!MEM_OUT_EN_N) |-> (!MEM_CHIP_SEL_N && MEM_WRITE_N && !MEM_DQ_OE)) // [RULE6]
        else $error("read strobes inconsistent");
    write_data_a: assert property (@(posedge CLOCK) disable iff (RESET)
        $rose(MEM_WRITE_N) |-> (MEM_DQ_OE && $stable(MEM_DQ_O) && $stable(MEM_ADDR))) // [RULE10]
        else $error("write data not held at strobe rise");
    write_width_a: assert property (@(posedge CLOCK) disable iff (RESET)
        $fell(MEM_WRITE_N) |-> !MEM_WRITE_N [*2]) // [RULE10]
        else $error("write strobe too short");
    read_access_a: assert property (@(posedge CLOCK) disable iff (RESET)
        $fell(MEM_OUT_EN_N) |-> !MEM_OUT_EN_N [*4]) // [RULE6]
        else $error("read access time too short");
    parallel_sel_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !MEM_PORT_SELECT) // [RULE2]
        else $error("serial port selected");

    cover_read_c:  cover property (@(posedge CLOCK) disable iff (RESET)
        $rose(MEM_OUT_EN_N) && RSP_VALID);
    cover_write_c: cover property (@(posedge CLOCK) disable iff (RESET) $rose(MEM_WRITE_N));
    cover_reset_c: cover property (@(posedge CLOCK) disable iff (RESET) $rose(MEM_RESET_N));

endmodule : pmem_host

/* pmem_dev_model.sv */
module pmem_dev_model #(
    parameter int unsigned ACCESS_NS   = 135,
    parameter int unsigned RECOVERY_NS = 200
) (
    input  wire logic [22:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rst_n,
    input  wire logic        port_sel,
    input  wire logic        lockout,
    input  wire logic [15:0] host_dq,
    input  wire logic        host_oe,
    output logic      [15:0] bus,
    output int               viol
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:255];
    logic [7:0]  status_q;
    logic        status_mode;
    logic        prog_armed;
    realtime     rel_t;
    logic        serial_on;
    logic        dev_oe;
    logic        wr_cyc;
    logic [24:0] settled;
    logic [15:0] dev_data;

    initial begin
        foreach (mem[i]) mem[i] = 16'(i) ^ 16'hc3a5;
        status_q = 8'h80;
        status_mode = 1'b0;
        prog_armed = 1'b0;
        viol = 0;
        rel_t = 0;
    end
    // Floating select reads as parallel
    assign serial_on = (port_sel === 1'b1);
    // serial_on only disables the parallel bus (no serial shift-out is modelled); the host never raises it
    assign dev_oe = rst_n && !ce_n && !oe_n && !serial_on;
    assign wr_cyc = rst_n && !ce_n && !we_n && oe_n && !serial_on;
    assign #(ACCESS_NS) settled = {addr, ce_n, oe_n};
    assign dev_data = status_mode ? {8'h00, status_q} : mem[addr[7:0]];
    // Unsettled or released bus shows the inverse, never a stale match
    assign bus = host_oe ? host_dq
               : (dev_oe && settled === {addr, ce_n, oe_n}) ? dev_data : ~dev_data;

    always @(posedge rst_n) rel_t = $realtime;
    // Programs finish at capture, so reset never leaves a half-written word
    always @(negedge rst_n) begin
        status_q = 8'h80;
        status_mode = 1'b0;
        prog_armed = 1'b0;
    end
    always @(negedge ce_n) if (rst_n && $realtime - rel_t < RECOVERY_NS) viol++;
    always @(negedge oe_n or negedge we_n) if (!oe_n && !we_n) viol++;
    always @(posedge host_oe or negedge oe_n) if (host_oe && !oe_n && !ce_n) viol++;
    // Capture at the first rising strobe ending the write
    always @(negedge wr_cyc) begin
        if (rst_n) begin
            if (!host_oe) viol++;
            if (prog_armed) begin
                prog_armed = 1'b0;
                status_mode = 1'b1;
                if (lockout) status_q[3] = 1'b1;
                else mem[addr[7:0]] = host_dq;
            end else begin
                case (host_dq[7:0])
                    8'hff: status_mode = 1'b0;
                    8'h70: status_mode = 1'b1;
                    8'h50: status_q = status_q & ~8'h3a;
                    8'h40: prog_armed = 1'b1;
                    default: ;
                endcase
            end
        end
    end
endmodule : pmem_dev_model

/* async_parallel_memory_bus_ops_tb.sv */
module async_parallel_memory_bus_ops_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clock, reset, req_valid, lockout;
    pmem_host_pkg::op_type req_op;
    logic [22:0]           req_addr, mem_addr;
    logic [15:0]           req_wdata, rsp_rdata, dq_o, dq_i;
    logic                  req_ready, rsp_valid, error_flag, cs_n, oe_n, we_n, rst_n;
    logic                  port_sel, dq_oe;
    int                    viol, cnt;
    int                    num_errors = 0;
    int                    n_checks = 0;

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    pmem_host i_dut (.CLOCK(clock), .RESET(reset), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .ERROR_FLAG(error_flag),
        .MEM_ADDR(mem_addr), .MEM_CHIP_SEL_N(cs_n), .MEM_OUT_EN_N(oe_n), .MEM_WRITE_N(we_n),
        .MEM_RESET_N(rst_n), .MEM_PORT_SELECT(port_sel), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe),
        .MEM_DQ_I(dq_i));
    pmem_dev_model i_dev (.addr(mem_addr), .ce_n(cs_n), .oe_n(oe_n), .we_n(we_n),
        .rst_n(rst_n), .port_sel(port_sel), .lockout(lockout), .host_dq(dq_o),
        .host_oe(dq_oe), .bus(dq_i), .viol(viol));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task automatic wait_for(input bit rsp);
        for (int i = 0; i < 200; i++) begin
            @(negedge clock);
            if ((rsp ? rsp_valid : req_ready) === 1'b1) return;
        end
        num_errors++;
        report_and_stop();
    endtask : wait_for

    task automatic do_req(input pmem_host_pkg::op_type op, input logic [22:0] a,
                          input logic [15:0] d);
        @(posedge clock);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        wait_for(1'b0);
        @(posedge clock);
        req_valid <= 1'b0;
        if (op == pmem_host_pkg::OP_READ || op == pmem_host_pkg::OP_WRITE) wait_for(1'b1);
    endtask : do_req

    task automatic program_word(input logic [22:0] a, input logic [15:0] d);
        do_req(pmem_host_pkg::OP_WRITE, a, 16'h0040);
        do_req(pmem_host_pkg::OP_WRITE, a, d);
    endtask : program_word

    task automatic read_check(input string name, input logic [22:0] a, input logic [15:0] exp);
        do_req(pmem_host_pkg::OP_READ, a, 16'h0000);
        check(name, rsp_rdata, exp);
    endtask : read_check

    task automatic t_reset;
        repeat (6) @(negedge clock);
        check("reset pin", {15'h0000, rst_n}, 16'h0000);
        check("strobes", {13'h0000, cs_n, oe_n, we_n}, 16'h0007);
        check("dq enable", {15'h0000, dq_oe}, 16'h0000);
        @(posedge clock);
        reset <= 1'b0;
        for (cnt = 0; cnt < 100 && req_ready !== 1'b1; cnt++) @(negedge clock);
        if (req_ready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        check("recovery", 16'(cnt >= pmem_host_pkg::RESET_RECOVERY_CYC), 16'h0001);
        check("reset released", {15'h0000, rst_n}, 16'h0001);
        check("port select", {15'h0000, port_sel}, 16'h0000);
        check("error flag", {15'h0000, error_flag}, 16'h0000);
    endtask : t_reset

    task automatic t_program;
        program_word(23'h000005, 16'hbeef);
        read_check("status after program", 23'h000005, 16'h0080);
        do_req(pmem_host_pkg::OP_WRITE, 23'h000000, 16'h00ff);
        read_check("programmed word", 23'h000005, 16'hbeef);
        read_check("neighbour word", 23'h000006, 16'hc3a3);
    endtask : t_program

    task automatic t_lockout;
        @(posedge clock);
        lockout <= 1'b1;
        program_word(23'h000005, 16'h1234);
        read_check("lockout status", 23'h000005, 16'h0088);
        do_req(pmem_host_pkg::OP_WRITE, 23'h000000, 16'h0050);
        read_check("cleared status", 23'h000005, 16'h0080);
        do_req(pmem_host_pkg::OP_WRITE, 23'h000000, 16'h00ff);
        read_check("protected word", 23'h000005, 16'hbeef);
        lockout <= 1'b0;
    endtask : t_lockout

    task automatic t_reset_op;
        do_req(pmem_host_pkg::OP_WRITE, 23'h000000, 16'h0070);
        do_req(pmem_host_pkg::OP_RESET, 23'h000000, 16'h0000);
        for (cnt = 0; cnt < 20 && rst_n !== 1'b0; cnt++) @(negedge clock);
        if (rst_n !== 1'b0) begin
            num_errors++;
            report_and_stop();
        end
        check("reset pulse", {15'h0000, rst_n}, 16'h0000);
        read_check("array after reset", 23'h000005, 16'hbeef);
    endtask : t_reset_op

    task automatic t_illegal;
        do_req(pmem_host_pkg::op_type'(2'h3), 23'h000000, 16'h0000);
        repeat (3) @(negedge clock);
        check("illegal op flag", {15'h0000, error_flag}, 16'h0001);
    endtask : t_illegal

    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_op = pmem_host_pkg::OP_READ;
        req_addr = 23'h000000;
        req_wdata = 16'h0000;
        lockout = 1'b0;
        t_reset();
        t_program();
        t_lockout();
        t_reset_op();
        t_illegal();
        check("bus protocol faults", 16'(viol), 16'h0000);
        report_and_stop();
    end
endmodule : async_parallel_memory_bus_ops_tb
